// ---- cmm_top.sv ----
/*
  Protected calibration memory with lock, RAM staging and supply-pin programming link.
  Assumes supply clock and data already sliced to logic levels; output pin is tri-stated outside.
*/
// What this block does
// - Every memory line including its check bit holds an odd count of ones.
// - Even bit positions summed over all lines give an even count.
// - Odd bit positions 1 to 7 summed over all lines give an odd count.
// - A single flipped bit is located by row and column and corrected.
// - Errors beyond one correctable bit force the output to full scale.
// - With lock bits programmed, nonvolatile contents change only through a factory write during reset.
// - With lock bits programmed, the link is ignored; application mode only.
// - All setup bits are written to a RAM copy without nonvolatile writes.
// - The array holds 135 data bits and 25 check bits.
// - Erase 80 ms, write 10 ms from supply clock; whole programming 100 ms.
// - Data moves both ways over supply and output pins; devices share by address.
// - Converter test mode drives output; converter values readable per calibration point.
`timescale 1ns/1ps
module cmm_top
  import cmm_pkg::*;
#(
  parameter logic [DEV_ADDR_W-1:0] DEV_ADDR      = 2'h0,
  parameter int                    ERASE_CYC     = ERASE_EDGES,
  parameter int                    WRITE_CYC     = WRITE_EDGES,
  parameter int                    PRG_MIN_CYC   = PRG_MIN_EDGES
)(
  input  wire logic                 mclk,
  input  wire logic                 srst,
  input  wire logic                 sup_clk_pin,
  input  wire logic                 sup_dat_pin,
  input  wire logic                 factory_wr,
  input  wire logic [MEM_BITS-1:0]  factory_img,
  input  wire logic [DAC_W-1:0]     app_code,
  input  wire logic [ADC_W-1:0]     adc_val,
  output logic                      out_pin_o,
  output logic                      out_pin_oe,
  output logic [DAC_W-1:0]          out_code,
  output logic [DATA_BITS-1:0]      cal_data,
  output logic                      mem_err,
  output logic                      bit_fixed,
  output logic                      locked,
  output logic                      app_mode,
  output logic                      prog_busy
);

  // ------------------------------------------------------------
  // Elaboration checks
  // ------------------------------------------------------------
  if (NUM_LINES * LINE_W != MEM_BITS ||
      (NUM_LINES - 1) * COL_CHK != DATA_BITS ||
      MEM_BITS - DATA_BITS != CHECK_BITS) begin : g_bad_map
    $error("cmm_top: memory map does not add up");
  end
  if (ERASE_CYC < 1 || WRITE_CYC < 1 ||
      PRG_MIN_CYC < ERASE_CYC + WRITE_CYC ||
      PRG_MIN_CYC >= (1 << CNT_W)) begin : g_bad_time
    $error("cmm_top: programming timing out of range");
  end
  if (DEV_ADDR == BCAST_ADDR) begin : g_bad_addr
    $error("cmm_top: device address equals broadcast address");
  end

  // ------------------------------------------------------------
  // Pin synchronisers and supply clock edges
  // ------------------------------------------------------------
  logic clk_s1_ff, clk_s2_ff, clk_s3_ff, dat_s1_ff, dat_s2_ff;
  logic nxt_clk_s1, nxt_clk_s2, nxt_clk_s3, nxt_dat_s1, nxt_dat_s2;
  logic sclk_rise, sclk_fall;

  always_comb begin
    nxt_clk_s1 = sup_clk_pin;
    nxt_clk_s2 = clk_s1_ff;
    nxt_clk_s3 = clk_s2_ff;
    nxt_dat_s1 = sup_dat_pin;
    nxt_dat_s2 = dat_s1_ff;
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      clk_s1_ff <= 1'b0;
      clk_s2_ff <= 1'b0;
      clk_s3_ff <= 1'b0;
      dat_s1_ff <= 1'b0;
      dat_s2_ff <= 1'b0;
    end else begin
      clk_s1_ff <= nxt_clk_s1;
      clk_s2_ff <= nxt_clk_s2;
      clk_s3_ff <= nxt_clk_s3;
      dat_s1_ff <= nxt_dat_s1;
      dat_s2_ff <= nxt_dat_s2;
    end
  end

  assign sclk_rise = clk_s2_ff && !clk_s3_ff;
  assign sclk_fall = !clk_s2_ff && clk_s3_ff;

  // ------------------------------------------------------------
  // Frame receiver: start bit then 20 bits, MSB first
  // ------------------------------------------------------------
  logic                  frm_act_ff, nxt_frm_act;
  logic [FCNT_W-1:0]     fcnt_ff, nxt_fcnt;
  logic [FRAME_BITS-1:0] shreg_ff, nxt_shreg;
  logic                  frm_vld_ff, nxt_frm_vld;
  cmm_frame_s            frame_ff, nxt_frame;
  logic                  locked_ff, nxt_locked;

  always_comb begin
    nxt_frm_act = frm_act_ff;
    nxt_fcnt    = fcnt_ff;
    nxt_shreg   = shreg_ff;
    nxt_frm_vld = 1'b0;
    nxt_frame   = frame_ff;
    if (locked_ff) begin
      nxt_frm_act = 1'b0;
    end else if (sclk_rise) begin
      if (!frm_act_ff) begin
        nxt_frm_act = dat_s2_ff;
        nxt_fcnt    = '0;
      end else begin
        nxt_shreg = {shreg_ff[FRAME_BITS-2:0], dat_s2_ff};
        nxt_fcnt  = fcnt_ff + 1'b1;
        if (fcnt_ff == FCNT_W'(FRAME_BITS - 1)) begin
          nxt_frm_act = 1'b0;
          nxt_frm_vld = 1'b1;
          nxt_frame   = cmm_frame_s'({shreg_ff[FRAME_BITS-2:0], dat_s2_ff});
        end
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      frm_act_ff <= 1'b0;
      fcnt_ff    <= '0;
      shreg_ff   <= '0;
      frm_vld_ff <= 1'b0;
      frame_ff   <= '0;
    end else begin
      frm_act_ff <= nxt_frm_act;
      fcnt_ff    <= nxt_fcnt;
      shreg_ff   <= nxt_shreg;
      frm_vld_ff <= nxt_frm_vld;
      frame_ff   <= nxt_frame;
    end
  end

  // ------------------------------------------------------------
  // Working copy, nonvolatile cells and checker
  // ------------------------------------------------------------
  logic [LINE_W-1:0]   work_ff [NUM_LINES];
  logic [LINE_W-1:0]   nxt_work [NUM_LINES];
  logic [LINE_W-1:0]   nvm_ff [NUM_LINES];
  logic [LINE_W-1:0]   nxt_nvm [NUM_LINES];
  logic [MEM_BITS-1:0] work_vec;
  cmm_chk_s            chk;

  for (genvar l = 0; l < NUM_LINES; l++) begin : g_flat
    assign work_vec[l*LINE_W +: LINE_W] = work_ff[l];
  end

  cmm_parity_chk u_chk (
    .mem (work_vec),
    .res (chk)
  );

  // ------------------------------------------------------------
  // Control: load, check, command handling, programming
  // ------------------------------------------------------------
  cmm_state_e          state_ff, nxt_state;
  logic [CNT_W-1:0]    cnt_ff, nxt_cnt;
  logic                prog_mode_ff, nxt_prog_mode;
  logic                test_mode_ff, nxt_test_mode;
  logic [LINE_W-1:0]   test_code_ff, nxt_test_code;
  logic [ADC_W-1:0]    cal_pt_ff [2];
  logic [ADC_W-1:0]    nxt_cal_pt [2];
  logic [LINE_W-1:0]   tx_ff, nxt_tx;
  logic [TCNT_W-1:0]   tcnt_ff, nxt_tcnt;
  logic                out_o_ff, nxt_out_o;
  logic                out_oe_ff, nxt_out_oe;
  logic [DAC_W-1:0]    code_ff, nxt_code;
  logic [DATA_BITS-1:0] data_ff, nxt_data;
  logic                err_ff, nxt_err;
  logic                fix_ff, nxt_fix;
  logic                hit;
  logic                own;

  assign hit = (frame_ff.addr == DEV_ADDR) || (frame_ff.addr == BCAST_ADDR);
  assign own = (frame_ff.addr == DEV_ADDR);

  always_comb begin
    nxt_state     = state_ff;
    nxt_cnt       = cnt_ff;
    nxt_locked    = locked_ff;
    nxt_prog_mode = prog_mode_ff;
    nxt_test_mode = test_mode_ff;
    nxt_test_code = test_code_ff;
    nxt_cal_pt    = cal_pt_ff;
    nxt_work      = work_ff;
    nxt_nvm       = nvm_ff;
    nxt_tx        = tx_ff;
    nxt_tcnt      = tcnt_ff;
    nxt_out_o     = out_o_ff;
    nxt_out_oe    = out_oe_ff;
    if (srst && factory_wr) begin
      for (int i = 0; i < NUM_LINES; i++) begin
        nxt_nvm[i] = factory_img[i*LINE_W +: LINE_W];
      end
    end
    case (state_ff)
      CMM_ST_LOAD: begin
        nxt_work  = nvm_ff;
        nxt_state = CMM_ST_CHECK;
      end
      CMM_ST_CHECK: begin
        nxt_locked = chk.fixed[LOCK_LINE*LINE_W + LOCK_POS_A] ||
                     chk.fixed[LOCK_LINE*LINE_W + LOCK_POS_B];
        nxt_state  = CMM_ST_RUN;
      end
      CMM_ST_RUN: begin
        if (frm_vld_ff && hit && !locked_ff) begin
          nxt_prog_mode = 1'b1;
          case (frame_ff.op)
            CMM_OP_WR_RAM: nxt_work[frame_ff.line] = frame_ff.data;
            CMM_OP_RD_RAM: nxt_tx = work_ff[frame_ff.line];
            CMM_OP_RD_NVM: nxt_tx = nvm_ff[frame_ff.line];
            CMM_OP_PROG: begin
              nxt_state = CMM_ST_ERASE;
              nxt_cnt   = '0;
            end
            CMM_OP_DAC_TEST: begin
              nxt_test_mode = 1'b1;
              nxt_test_code = frame_ff.data;
            end
            CMM_OP_CAPTURE: nxt_cal_pt[frame_ff.line[0]] = adc_val;
            CMM_OP_RD_ADC: nxt_tx = cal_pt_ff[frame_ff.line[0]];
            CMM_OP_EXIT: begin
              nxt_test_mode = 1'b0;
              nxt_prog_mode = 1'b0;
            end
            default: nxt_prog_mode = 1'b1;
          endcase
          if (own && (frame_ff.op == CMM_OP_RD_RAM || frame_ff.op == CMM_OP_RD_NVM ||
                      frame_ff.op == CMM_OP_RD_ADC)) begin
            nxt_tcnt = TCNT_W'(LINE_W);
          end
        end
      end
      CMM_ST_ERASE: begin
        if (sclk_rise) begin
          nxt_cnt = cnt_ff + 1'b1;
        end
        if (cnt_ff == CNT_W'(ERASE_CYC)) begin
          for (int i = 0; i < NUM_LINES; i++) begin
            nxt_nvm[i] = '0;
          end
          nxt_state = CMM_ST_WRITE;
        end
      end
      CMM_ST_WRITE: begin
        if (sclk_rise) begin
          nxt_cnt = cnt_ff + 1'b1;
        end
        if (cnt_ff == CNT_W'(ERASE_CYC + WRITE_CYC)) begin
          nxt_nvm   = work_ff;
          nxt_state = CMM_ST_HOLD;
        end
      end
      CMM_ST_HOLD: begin
        if (sclk_rise) begin
          nxt_cnt = cnt_ff + 1'b1;
        end
        if (cnt_ff >= CNT_W'(PRG_MIN_CYC)) begin
          nxt_state = CMM_ST_LOAD;
        end
      end
      default: nxt_state = CMM_ST_LOAD;
    endcase
    if (locked_ff) begin
      nxt_prog_mode = 1'b0;
      nxt_test_mode = 1'b0;
    end
    if (sclk_fall) begin
      if (tcnt_ff != '0) begin
        nxt_out_o  = tx_ff[LINE_W-1];
        nxt_out_oe = 1'b1;
        nxt_tx     = {tx_ff[LINE_W-2:0], 1'b0};
        nxt_tcnt   = tcnt_ff - 1'b1;
      end else begin
        nxt_out_o  = 1'b0;
        nxt_out_oe = 1'b0;
      end
    end
  end

  // Output code and corrected data
  always_comb begin
    nxt_err  = (state_ff != CMM_ST_LOAD) && (state_ff != CMM_ST_CHECK) && chk.uncorrectable;
    nxt_fix  = chk.corrected;
    nxt_data = data_ff;
    for (int i = 0; i < NUM_LINES - 1; i++) begin
      nxt_data[i*COL_CHK +: COL_CHK] = chk.fixed[i*LINE_W +: COL_CHK];
    end
    if (nxt_err) begin
      nxt_code = DAC_FULL;
    end else if (test_mode_ff) begin
      nxt_code = {test_code_ff, 2'b00};
    end else begin
      nxt_code = app_code;
    end
  end

  always_ff @(posedge mclk) begin
    nvm_ff <= nxt_nvm;
    if (srst) begin
      state_ff     <= CMM_ST_LOAD;
      cnt_ff       <= '0;
      locked_ff    <= 1'b0;
      prog_mode_ff <= 1'b0;
      test_mode_ff <= 1'b0;
      test_code_ff <= '0;
      cal_pt_ff    <= '{default: '0};
      work_ff      <= '{default: '0};
      tx_ff        <= '0;
      tcnt_ff      <= '0;
      out_o_ff     <= 1'b0;
      out_oe_ff    <= 1'b0;
      code_ff      <= DAC_RESET;
      data_ff      <= '0;
      err_ff       <= 1'b0;
      fix_ff       <= 1'b0;
    end else begin
      state_ff     <= nxt_state;
      cnt_ff       <= nxt_cnt;
      locked_ff    <= nxt_locked;
      prog_mode_ff <= nxt_prog_mode;
      test_mode_ff <= nxt_test_mode;
      test_code_ff <= nxt_test_code;
      cal_pt_ff    <= nxt_cal_pt;
      work_ff      <= nxt_work;
      tx_ff        <= nxt_tx;
      tcnt_ff      <= nxt_tcnt;
      out_o_ff     <= nxt_out_o;
      out_oe_ff    <= nxt_out_oe;
      code_ff      <= nxt_code;
      data_ff      <= nxt_data;
      err_ff       <= nxt_err;
      fix_ff       <= nxt_fix;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign out_pin_o  = out_o_ff;
  assign out_pin_oe = out_oe_ff;
  assign out_code   = code_ff;
  assign cal_data   = data_ff;
  assign mem_err    = err_ff;
  assign bit_fixed  = fix_ff;
  assign locked     = locked_ff;
  assign app_mode   = !prog_mode_ff;
  assign prog_busy  = (state_ff == CMM_ST_ERASE) || (state_ff == CMM_ST_WRITE) ||
                      (state_ff == CMM_ST_HOLD);

endmodule : cmm_top

// ---- cmm_pkg.sv ----
/*
  Shared constants, commands, states and carriers for the protected calibration memory.
  Assumes one 10 MHz system clock and a programming clock sent over the supply pin.
*/
package cmm_pkg;

  // ------------------------------------------------------------
  // Memory matrix layout
  // ------------------------------------------------------------
  localparam int NUM_LINES   = 16;
  localparam int LINE_W      = 10;
  localparam int LADDR_W     = 4;
  localparam int COL_CHK     = 9;
  localparam int ROWPAR_POS  = 9;
  localparam int PARITY_LINE = 15;
  localparam int MEM_BITS    = 160;
  localparam int DATA_BITS   = 135;
  localparam int CHECK_BITS  = 25;
  localparam int LOCK_LINE   = 14;
  localparam int LOCK_POS_A  = 8;
  localparam int LOCK_POS_B  = 7;

  // ------------------------------------------------------------
  // Link and output
  // ------------------------------------------------------------
  localparam int          DEV_ADDR_W = 2;
  localparam logic [1:0]  BCAST_ADDR = 2'h3;
  localparam int          FRAME_BITS = 20;
  localparam int          FCNT_W     = 5;
  localparam int          TCNT_W     = 4;
  localparam int          DAC_W      = 12;
  localparam int          ADC_W      = 10;
  localparam logic [11:0] DAC_FULL   = 12'hfff;
  localparam logic [11:0] DAC_RESET  = 12'h000;

  // ------------------------------------------------------------
  // Nonvolatile write timing, counted in supply clock edges
  // ------------------------------------------------------------
  localparam int CNT_W          = 18;
  localparam int LINK_PERIOD_NS = 800;
  localparam int WRITE_PULSE_MS = 10;
  localparam int ERASE_PULSE_MS = 80;
  localparam int PRG_MIN_MS     = 100;
  localparam int WRITE_EDGES    = (WRITE_PULSE_MS * 1000000) / LINK_PERIOD_NS;
  localparam int ERASE_EDGES    = (ERASE_PULSE_MS * 1000000) / LINK_PERIOD_NS;
  localparam int PRG_MIN_EDGES  = (PRG_MIN_MS * 1000000 + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS;

  // ------------------------------------------------------------
  // Commands, states, carriers
  // ------------------------------------------------------------
  typedef enum logic [3:0] {
    CMM_OP_NOP      = 4'h0,
    CMM_OP_WR_RAM   = 4'h1,
    CMM_OP_RD_RAM   = 4'h2,
    CMM_OP_RD_NVM   = 4'h3,
    CMM_OP_PROG     = 4'h4,
    CMM_OP_DAC_TEST = 4'h5,
    CMM_OP_CAPTURE  = 4'h6,
    CMM_OP_RD_ADC   = 4'h7,
    CMM_OP_EXIT     = 4'h8
  } cmm_op_e;

  typedef enum logic [5:0] {
    CMM_ST_LOAD  = 6'h01,
    CMM_ST_CHECK = 6'h02,
    CMM_ST_RUN   = 6'h04,
    CMM_ST_ERASE = 6'h08,
    CMM_ST_WRITE = 6'h10,
    CMM_ST_HOLD  = 6'h20
  } cmm_state_e;

  typedef struct packed {
    logic [DEV_ADDR_W-1:0] addr;
    cmm_op_e               op;
    logic [LADDR_W-1:0]    line;
    logic [LINE_W-1:0]     data;
  } cmm_frame_s;

  typedef struct packed {
    logic [MEM_BITS-1:0] fixed;
    logic                corrected;
    logic                uncorrectable;
  } cmm_chk_s;

endpackage : cmm_pkg

// ---- cmm_parity_chk.sv ----
/*
  Matrix parity checker and single-bit corrector for the calibration memory.
  Assumes a flat image, line l at bits l*10 upward, row check bit at position 9.
*/
`timescale 1ns/1ps
module cmm_parity_chk
  import cmm_pkg::*;
(
  input  wire logic [MEM_BITS-1:0] mem,
  output cmm_chk_s                 res
);

  logic [NUM_LINES-1:0] row_fail;
  logic [COL_CHK-1:0]   col_fail;
  logic [MEM_BITS-1:0]  flip;
  logic                 row_one;
  logic                 row_none;
  logic                 col_one;
  logic                 col_none;
  logic                 fix_ok;

  // ------------------------------------------------------------
  // Row and column checks
  // ------------------------------------------------------------
  for (genvar r = 0; r < NUM_LINES; r++) begin : g_row
    assign row_fail[r] = ~(^mem[r*LINE_W +: LINE_W]);
  end

  for (genvar c = 0; c < COL_CHK; c++) begin : g_col
    localparam logic ODD = ((c % 2) == 1);
    logic [NUM_LINES-1:0] colv;
    for (genvar k = 0; k < NUM_LINES; k++) begin : g_bit
      assign colv[k] = mem[k*LINE_W + c];
    end
    assign col_fail[c] = (^colv) ^ ODD;
  end

  // ------------------------------------------------------------
  // Locate and correct
  // ------------------------------------------------------------
  assign row_none = (row_fail == '0);
  assign row_one  = !row_none && ((row_fail & (row_fail - 1'b1)) == '0);
  assign col_none = (col_fail == '0);
  assign col_one  = !col_none && ((col_fail & (col_fail - 1'b1)) == '0);
  assign fix_ok   = row_one && (col_one || col_none);

  for (genvar r = 0; r < NUM_LINES; r++) begin : g_fix
    for (genvar c = 0; c < LINE_W; c++) begin : g_pos
      if (c == ROWPAR_POS) begin : g_rp
        assign flip[r*LINE_W + c] = fix_ok && row_fail[r] && col_none;
      end else begin : g_dp
        assign flip[r*LINE_W + c] = fix_ok && row_fail[r] && col_fail[c];
      end
    end
  end

  assign res.fixed         = mem ^ flip;
  assign res.corrected     = fix_ok;
  assign res.uncorrectable = !(row_none && col_none) && !fix_ok;

endmodule : cmm_parity_chk

// ---- cmm_checker.sv ----
/*
  Port assertions for the protected calibration memory.
  Assumes it is bound into cmm_top and handed its programming length.
*/
`timescale 1ns/1ps
module cmm_checker
  import cmm_pkg::*;
#(
  parameter int PRG_MIN_CYC = 16
)(
  input wire logic                 mclk,
  input wire logic                 srst,
  input wire logic                 sup_clk_pin,
  input wire logic [DAC_W-1:0]     app_code,
  input wire logic                 out_pin_oe,
  input wire logic [DAC_W-1:0]     out_code,
  input wire logic [DATA_BITS-1:0] cal_data,
  input wire logic                 mem_err,
  input wire logic                 bit_fixed,
  input wire logic                 locked,
  input wire logic                 app_mode,
  input wire logic                 prog_busy
);
  // ----
  // Link edges while busy, reply length
  // ----
  logic        clk_q_ff;
  logic [17:0] edge_cnt_ff;
  logic [7:0]  oe_cnt_ff;
  always_ff @(posedge mclk) begin
    clk_q_ff    <= sup_clk_pin;
    edge_cnt_ff <= prog_busy ? edge_cnt_ff + 18'(sup_clk_pin & ~clk_q_ff) : 18'h0;
    oe_cnt_ff   <= out_pin_oe ? oe_cnt_ff + 8'h01 : 8'h00;
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);
  // ----
  // Assertions
  // ----
  chk_err_full: assert property (mem_err [*2] |-> out_code == DAC_FULL)
    else $error("output not full scale on memory error");
  chk_fix_excl: assert property (!(bit_fixed && mem_err))
    else $error("fix and error flags together");
  chk_lock_app: assert property (locked [*2] |-> app_mode)
    else $error("locked device left application mode");
  chk_lock_quiet: assert property (locked |-> !out_pin_oe && !prog_busy)
    else $error("locked device drives link or programs");
  chk_lock_frozen: assert property (locked [*6] |-> $stable(cal_data))
    else $error("locked data changed");
  chk_app_pass: assert property (app_mode && $past(app_mode) && !mem_err
    && !$past(mem_err) && !$past(srst) |-> out_code == $past(app_code))
    else $error("output code not the signal path code");
  chk_load_quiet: assert property ($fell(srst) |-> !mem_err ##1 !mem_err)
    else $error("error flag before check");
  chk_prog_len: assert property ($fell(prog_busy) |-> edge_cnt_ff >= 18'(PRG_MIN_CYC))
    else $error("programming cycle too short");
  chk_reply_min: assert property ($rose(out_pin_oe) |-> out_pin_oe [*8])
    else $error("reply bit too short");
  chk_reply_max: assert property (oe_cnt_ff <= 8'h5a)
    else $error("reply too long");
endmodule : cmm_checker

bind cmm_top cmm_checker #(.PRG_MIN_CYC(PRG_MIN_CYC)) u_cmm_checker (.mclk, .srst, .sup_clk_pin,
  .app_code, .out_pin_oe, .out_code, .cal_data, .mem_err, .bit_fixed, .locked, .app_mode,
  .prog_busy);

// ---- cmm_prog_model.sv ----
/*
  Programmer model: clocks frames over the supply pin and collects replies.
  Assumes a pull-down load on the output pin while the device is silent.
*/
`timescale 1ns/1ps
module cmm_prog_model
  import cmm_pkg::*;
#(
  parameter int HALF_NS = LINK_PERIOD_NS / 2
)(
  output logic      sup_clk_pin,
  output logic      sup_dat_pin,
  input  wire logic out_pin_o,
  input  wire logic out_pin_oe
);
  logic [LINE_W-1:0] rep_q;
  int                rep_n;
  logic              out_line;
  assign out_line = out_pin_oe ? out_pin_o : 1'b0;
  initial begin
    sup_clk_pin = 1'b0;
    sup_dat_pin = 1'b0;
  end
  // ----
  // Link periods
  // ----
  task automatic tick(input logic d);
    sup_dat_pin = d;
    #(HALF_NS);
    sup_clk_pin = 1'b1;
    if (out_pin_oe === 1'b1) begin
      rep_q = {rep_q[LINE_W-2:0], out_line};
      rep_n++;
    end
    #(HALF_NS);
    sup_clk_pin = 1'b0;
  endtask : tick
  task automatic run(input int n);
    repeat (n) tick(1'b0);
  endtask : run
  task automatic send(input cmm_frame_s f);
    rep_q = '0;
    rep_n = 0;
    #13;
    tick(1'b1);
    for (int i = FRAME_BITS - 1; i >= 0; i--) tick(f[i]);
    run(12);
    sup_dat_pin = ~sup_dat_pin;
  endtask : send
endmodule : cmm_prog_model

// ---- cmm_top_tb.sv ----
/*
  Self-checking bench for cmm_top.
  Assumes the programmer model on the link and the bound checker.
*/
`timescale 1ns/1ps
module cmm_top_tb
  import cmm_pkg::*;
;
  localparam int                   PRG = 16;
  localparam logic [DATA_BITS-1:0] D0  = {9'h025, {14{9'h0a5}}};
  logic                 mclk        = 1'b0;
  logic                 srst        = 1'b1;
  logic                 factory_wr  = 1'b0;
  logic [MEM_BITS-1:0]  factory_img = '0;
  logic [DAC_W-1:0]     app_code    = 12'h5a3;
  logic [ADC_W-1:0]     adc_val     = 10'h000;
  logic [DAC_W-1:0]     out_code;
  logic [DATA_BITS-1:0] cal_data, d1, d2;
  logic [MEM_BITS-1:0]  img1, img2;
  logic sup_clk_pin, sup_dat_pin, out_pin_o, out_pin_oe;
  logic mem_err, bit_fixed, locked, app_mode, prog_busy;
  int   err_total = 0, tests_run = 0, cyc = 0;

  cmm_top #(.ERASE_CYC(8), .WRITE_CYC(4), .PRG_MIN_CYC(PRG)) dut (.mclk, .srst, .sup_clk_pin,
    .sup_dat_pin, .factory_wr, .factory_img, .app_code, .adc_val, .out_pin_o, .out_pin_oe,
    .out_code, .cal_data, .mem_err, .bit_fixed, .locked, .app_mode, .prog_busy);
  cmm_prog_model prg (.sup_clk_pin, .sup_dat_pin, .out_pin_o, .out_pin_oe);

  always #50 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 30000) begin
      err_total++;
      final_report();
    end
  end
  // ----
  // Helpers
  // ----
  function automatic logic [MEM_BITS-1:0] mk_img(input logic [DATA_BITS-1:0] d);
    logic [MEM_BITS-1:0] m;
    m = '0;
    for (int l = 0; l < 15; l++) m[l*10 +: 9] = d[l*9 +: 9];
    for (int p = 0; p < 9; p++) begin
      m[150+p] = p[0];
      for (int l = 0; l < 15; l++) m[150+p] ^= m[l*10+p];
    end
    for (int l = 0; l < 16; l++) m[l*10+9] = ~^m[l*10 +: 9];
    return m;
  endfunction : mk_img
  task automatic check(input logic [DATA_BITS-1:0] got, exp, input string msg);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %0t %s", $time, msg);
    end
  endtask : check
  task automatic boot(input logic wr, input logic [MEM_BITS-1:0] img);
    @(negedge mclk);
    srst = 1'b1;
    factory_wr = wr;
    factory_img = img;
    repeat (4) @(negedge mclk);
    srst = 1'b0;
    factory_wr = 1'b0;
    repeat (8) @(negedge mclk);
  endtask : boot
  task automatic fr(input logic [1:0] a, input cmm_op_e op, input logic [3:0] ln,
                    input logic [9:0] d);
    prg.send({a, op, ln, d});
    @(negedge mclk);
  endtask : fr
  task automatic final_report();
    if (err_total == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : final_report
  // ----
  // Scenarios
  // ----
  task automatic sc_fix();
    int unsigned         pos [3] = '{43, 79, 152};
    logic [MEM_BITS-1:0] m;
    boot(1'b1, mk_img(D0));
    check(cal_data, D0, "clean data");
    check({mem_err, bit_fixed, locked}, 3'h0, "clean flags");
    foreach (pos[i]) begin
      m = mk_img(D0);
      m[pos[i]] = ~m[pos[i]];
      boot(1'b1, m);
      check(cal_data, D0, "corrected data");
      check({mem_err, bit_fixed}, 2'h1, "single fix flags");
    end
    boot(1'b1, mk_img(D0) ^ (160'h1 << 43) ^ (160'h1 << 79));
    check(mem_err, 1'b1, "double error");
    check(out_code, DAC_FULL, "error level");
    boot(1'b1, '0);
    check(mem_err, 1'b1, "erased array");
  endtask : sc_fix
  task automatic sc_ram();
    logic [MEM_BITS-1:0] m0;
    m0 = mk_img(D0);
    d1 = D0;
    d1[18 +: 9] = 9'h133;
    img1 = mk_img(d1);
    boot(1'b1, m0);
    fr(2'h0, CMM_OP_WR_RAM, 4'h2, img1[29:20]);
    fr(BCAST_ADDR, CMM_OP_WR_RAM, 4'hf, img1[159:150]);
    fr(2'h1, CMM_OP_WR_RAM, 4'h2, 10'h000);
    check(cal_data, d1, "staged data");
    check({mem_err, bit_fixed, app_mode}, 3'h0, "staged flags");
    fr(2'h0, CMM_OP_RD_RAM, 4'h2, 10'h000);
    check(prg.rep_q, img1[29:20], "ram read");
    check(prg.rep_n, 10, "reply length");
    fr(2'h0, CMM_OP_RD_NVM, 4'h2, 10'h000);
    check(prg.rep_q, m0[29:20], "cells untouched");
    fr(BCAST_ADDR, CMM_OP_RD_RAM, 4'h2, 10'h000);
    check(prg.rep_n, 0, "broadcast silent");
  endtask : sc_ram
  task automatic sc_conv();
    fr(2'h0, CMM_OP_DAC_TEST, 4'h0, 10'h2c3);
    check(out_code, {10'h2c3, 2'b00}, "test code");
    adc_val = 10'h1e7;
    fr(2'h0, CMM_OP_CAPTURE, 4'h0, 10'h000);
    adc_val = 10'h09c;
    fr(2'h0, CMM_OP_CAPTURE, 4'h1, 10'h000);
    fr(2'h0, CMM_OP_RD_ADC, 4'h0, 10'h000);
    check(prg.rep_q, 10'h1e7, "point one");
    fr(2'h0, CMM_OP_RD_ADC, 4'h1, 10'h000);
    check(prg.rep_q, 10'h09c, "point two");
    fr(2'h0, CMM_OP_NOP, 4'h0, 10'h000);
    fr(2'h0, CMM_OP_EXIT, 4'h0, 10'h000);
    app_code = 12'h3c6;
    repeat (2) @(negedge mclk);
    check({app_mode, out_code}, {1'b1, 12'h3c6}, "back to application");
  endtask : sc_conv
  task automatic sc_prog();
    int t;
    fr(2'h0, CMM_OP_PROG, 4'h0, 10'h000);
    check(prog_busy, 1'b1, "busy");
    t = 12;
    while (prog_busy === 1'b1 && t < 40) begin
      prg.run(1);
      t++;
    end
    check(t >= PRG && t <= PRG + 1, 1'b1, "program length");
    prg.run(4);
    fr(2'h0, CMM_OP_RD_NVM, 4'h2, 10'h000);
    check(prg.rep_q, img1[29:20], "cells written");
    boot(1'b0, '0);
    check(cal_data, d1, "reload");
  endtask : sc_prog
  task automatic sc_lock();
    d2 = d1;
    d2[134] = 1'b1;
    img2 = mk_img(d2);
    fr(2'h0, CMM_OP_WR_RAM, 4'he, img2[149:140]);
    fr(2'h0, CMM_OP_WR_RAM, 4'hf, img2[159:150]);
    fr(2'h0, CMM_OP_PROG, 4'h0, 10'h000);
    prg.run(12);
    check({locked, app_mode}, 2'h3, "locked");
    fr(2'h0, CMM_OP_WR_RAM, 4'h2, 10'h000);
    check(cal_data, d2, "frozen");
    fr(2'h0, CMM_OP_RD_NVM, 4'h2, 10'h000);
    check(prg.rep_n, 0, "link ignored");
    boot(1'b0, '0);
    check(locked, 1'b1, "lock kept");
    check(cal_data, d2, "locked data kept");
  endtask : sc_lock

  initial begin
    sc_fix();
    sc_ram();
    sc_conv();
    sc_prog();
    sc_lock();
    final_report();
  end
endmodule : cmm_top_tb
